// ---- hdl/ext_pin_edge_interrupts.sv ----
// External pin edge interrupt block: three pin groups, edge enables, request flags, SFR access.
// Assumes an 8-bit SFR bus from the CPU core with one-cycle read data and per-group acknowledges.
`timescale 1ns/1ps
`include "ext_int_params.svh"

module ext_pin_edge_interrupts (
  input  wire logic                          sys_clk_i,         // System clock, 125 MHz
  input  wire logic                          rst_n_i,           // Synchronous reset, active low
  input  wire ext_int_pkg::sfr_req_type      sfr_req_i,         // SFR address, strobes, write data
  output logic                [7:0]          sfr_rdata_o,       // SFR read data, one cycle after rd
  output logic                               sfr_hit_o,         // Read address belongs to this block
  input  wire logic           [3:1]          ext_pin_group0_i,  // Group 0 pins 1..3
  input  wire logic           [3:0]          ext_pin_group1_i,  // Group 1 pins 0..3
  input  wire logic           [5:0]          ext_pin_group2_i,  // Group 2 pins 0..5
  input  wire ext_int_pkg::irq_group_type    irq_ack_i,         // CPU response per group
  output ext_int_pkg::irq_group_type         irq_req_o          // Request per group to the CPU
);
  import ext_int_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] g0_fall_reg, g0_rise_reg, g1_fall_reg, g1_rise_reg, g2_fall_reg, g2_rise_reg;
  logic [7:0] g0_fall_next, g0_rise_next, g1_fall_next, g1_rise_next, g2_fall_next, g2_rise_next;
  logic [7:0] en_main_reg, en_second_reg, en_main_next, en_second_next;
  logic       group0_request_flag_reg, group1_request_flag_reg, group2_pending_reg;
  logic       group0_request_flag_next, group1_request_flag_next, group2_pending_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       hit_reg, hit_next;

  logic [2:0] g0_rise, g0_fall;
  logic [3:0] g1_rise, g1_fall;
  logic [5:0] g2_rise, g2_fall;
  logic       g0_event, g1_event, g2_event;
  logic       wr_control;

  // ****************************************
  // Pin synchronisers and edge detectors
  // ****************************************
  pin_edge_detect #(.WIDTH(3)) u_edge_g0 (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ext_pin_group0_i),
    .rise_o    (g0_rise),
    .fall_o    (g0_fall)
  );

  pin_edge_detect #(.WIDTH(4)) u_edge_g1 (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ext_pin_group1_i),
    .rise_o    (g1_rise),
    .fall_o    (g1_fall)
  );

  pin_edge_detect #(.WIDTH(6)) u_edge_g2 (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ext_pin_group2_i),
    .rise_o    (g2_rise),
    .fall_o    (g2_fall)
  );

  // ****************************************
  // Enabled edges, ORed per group
  // ****************************************
  assign g0_event = |((g0_fall & g0_fall_reg[3:1]) | (g0_rise & g0_rise_reg[3:1]));
  assign g1_event = |((g1_fall & g1_fall_reg[3:0]) | (g1_rise & g1_rise_reg[3:0]));
  assign g2_event = |((g2_fall & g2_fall_reg[5:0]) | (g2_rise & g2_rise_reg[5:0]));

  assign wr_control = sfr_req_i.wr && (sfr_req_i.addr == `ADDR_TIMER_AND_EXT_INT_CONTROL);

  // ****************************************
  // Register writes
  // ****************************************
  always_comb begin
    g0_fall_next   = g0_fall_reg;
    g0_rise_next   = g0_rise_reg;
    g1_fall_next   = g1_fall_reg;
    g1_rise_next   = g1_rise_reg;
    g2_fall_next   = g2_fall_reg;
    g2_rise_next   = g2_rise_reg;
    en_main_next   = en_main_reg;
    en_second_next = en_second_reg;
    if (sfr_req_i.wr) begin
      if (sfr_req_i.addr == `ADDR_GROUP0_FALLING_EDGE) begin
        g0_fall_next = sfr_req_i.wdata & `MASK_GROUP0_EDGE;
      end else if (sfr_req_i.addr == `ADDR_GROUP0_RISING_EDGE) begin
        g0_rise_next = sfr_req_i.wdata & `MASK_GROUP0_EDGE;
      end else if (sfr_req_i.addr == `ADDR_GROUP1_FALLING_EDGE) begin
        g1_fall_next = sfr_req_i.wdata & `MASK_GROUP1_EDGE;
      end else if (sfr_req_i.addr == `ADDR_GROUP1_RISING_EDGE) begin
        g1_rise_next = sfr_req_i.wdata & `MASK_GROUP1_EDGE;
      end else if (sfr_req_i.addr == `ADDR_GROUP2_FALLING_EDGE) begin
        g2_fall_next = sfr_req_i.wdata & `MASK_GROUP2_EDGE;
      end else if (sfr_req_i.addr == `ADDR_GROUP2_RISING_EDGE) begin
        g2_rise_next = sfr_req_i.wdata & `MASK_GROUP2_EDGE;
      end else if (sfr_req_i.addr == `ADDR_IRQ_ENABLE_MAIN) begin
        en_main_next = sfr_req_i.wdata & `MASK_ENABLE_MAIN;
      end else if (sfr_req_i.addr == `ADDR_IRQ_ENABLE_SECOND) begin
        en_second_next = sfr_req_i.wdata & `MASK_ENABLE_SECOND;
      end
    end
  end

  // ****************************************
  // Request flags: a new edge wins over any clear
  // ****************************************
  always_comb begin
    group0_request_flag_next = group0_request_flag_reg;
    group1_request_flag_next = group1_request_flag_reg;
    group2_pending_next      = group2_pending_reg;
    if (wr_control) begin
      group0_request_flag_next = sfr_req_i.wdata[`BIT_GROUP0_REQUEST_FLAG];
      group1_request_flag_next = sfr_req_i.wdata[`BIT_GROUP1_REQUEST_FLAG];
    end
    if (irq_ack_i.group0) begin
      group0_request_flag_next = 1'b0;
    end
    if (irq_ack_i.group1) begin
      group1_request_flag_next = 1'b0;
    end
    if (irq_ack_i.group2) begin
      group2_pending_next = 1'b0;
    end
    if (g0_event) begin
      group0_request_flag_next = 1'b1;
    end
    if (g1_event) begin
      group1_request_flag_next = 1'b1;
    end
    if (g2_event) begin
      group2_pending_next = 1'b1;
    end
  end

  // ****************************************
  // Read path, registered
  // ****************************************
  always_comb begin
    rdata_next = rdata_reg;
    hit_next   = hit_reg;
    if (sfr_req_i.rd) begin
      hit_next = 1'b1;
      if (sfr_req_i.addr == `ADDR_TIMER_AND_EXT_INT_CONTROL) begin
        rdata_next = `RESET_BYTE;
        rdata_next[`BIT_GROUP1_REQUEST_FLAG] = group1_request_flag_reg;
        rdata_next[`BIT_GROUP0_REQUEST_FLAG] = group0_request_flag_reg;
      end else if (sfr_req_i.addr == `ADDR_GROUP0_FALLING_EDGE) begin
        rdata_next = g0_fall_reg;
      end else if (sfr_req_i.addr == `ADDR_GROUP0_RISING_EDGE) begin
        rdata_next = g0_rise_reg;
      end else if (sfr_req_i.addr == `ADDR_GROUP1_FALLING_EDGE) begin
        rdata_next = g1_fall_reg;
      end else if (sfr_req_i.addr == `ADDR_GROUP1_RISING_EDGE) begin
        rdata_next = g1_rise_reg;
      end else if (sfr_req_i.addr == `ADDR_GROUP2_FALLING_EDGE) begin
        rdata_next = g2_fall_reg;
      end else if (sfr_req_i.addr == `ADDR_GROUP2_RISING_EDGE) begin
        rdata_next = g2_rise_reg;
      end else if (sfr_req_i.addr == `ADDR_IRQ_ENABLE_MAIN) begin
        rdata_next = en_main_reg;
      end else if (sfr_req_i.addr == `ADDR_IRQ_ENABLE_SECOND) begin
        rdata_next = en_second_reg;
      end else begin
        rdata_next = `RESET_BYTE;
        hit_next   = 1'b0;
      end
    end else begin
      hit_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      g0_fall_reg             <= `RESET_BYTE;
      g0_rise_reg             <= `RESET_BYTE;
      g1_fall_reg             <= `RESET_BYTE;
      g1_rise_reg             <= `RESET_BYTE;
      g2_fall_reg             <= `RESET_BYTE;
      g2_rise_reg             <= `RESET_BYTE;
      en_main_reg             <= `RESET_BYTE;
      en_second_reg           <= `RESET_BYTE;
      group0_request_flag_reg <= 1'b0;
      group1_request_flag_reg <= 1'b0;
      group2_pending_reg      <= 1'b0;
      rdata_reg               <= `RESET_BYTE;
      hit_reg                 <= 1'b0;
    end else begin
      g0_fall_reg             <= g0_fall_next;
      g0_rise_reg             <= g0_rise_next;
      g1_fall_reg             <= g1_fall_next;
      g1_rise_reg             <= g1_rise_next;
      g2_fall_reg             <= g2_fall_next;
      g2_rise_reg             <= g2_rise_next;
      en_main_reg             <= en_main_next;
      en_second_reg           <= en_second_next;
      group0_request_flag_reg <= group0_request_flag_next;
      group1_request_flag_reg <= group1_request_flag_next;
      group2_pending_reg      <= group2_pending_next;
      rdata_reg               <= rdata_next;
      hit_reg                 <= hit_next;
    end
  end

  // ****************************************
  // Requests to the CPU
  // ****************************************
  always_comb begin
    irq_req_o.group0 = group0_request_flag_reg & en_main_reg[`BIT_GROUP0_IRQ_ENABLE]
                       & en_main_reg[`BIT_GLOBAL_IRQ_ENABLE];
    irq_req_o.group1 = group1_request_flag_reg & en_main_reg[`BIT_GROUP1_IRQ_ENABLE]
                       & en_main_reg[`BIT_GLOBAL_IRQ_ENABLE];
    irq_req_o.group2 = group2_pending_reg & en_second_reg[`BIT_GROUP2_IRQ_ENABLE]
                       & en_main_reg[`BIT_GLOBAL_IRQ_ENABLE];
  end

  assign sfr_rdata_o = rdata_reg;
  assign sfr_hit_o   = hit_reg;

endmodule

// ---- hdl/ext_int_params.svh ----
// Register addresses, field positions and reset values for the external pin edge interrupt block.
// Assumes inclusion by the package and design files of this block only.
`ifndef EXT_INT_PARAMS_SVH
`define EXT_INT_PARAMS_SVH

`define ADDR_TIMER_AND_EXT_INT_CONTROL 8'h88
`define ADDR_IRQ_ENABLE_MAIN           8'hA8
`define ADDR_IRQ_ENABLE_SECOND         8'hA9
`define ADDR_GROUP0_FALLING_EDGE       8'hBA
`define ADDR_GROUP0_RISING_EDGE        8'hBB
`define ADDR_GROUP1_FALLING_EDGE       8'hBC
`define ADDR_GROUP1_RISING_EDGE        8'hBD
`define ADDR_GROUP2_FALLING_EDGE       8'hC6
`define ADDR_GROUP2_RISING_EDGE        8'hC7

`define BIT_GROUP1_REQUEST_FLAG 3
`define BIT_GROUP0_REQUEST_FLAG 1
`define BIT_GLOBAL_IRQ_ENABLE   7
`define BIT_GROUP1_IRQ_ENABLE   2
`define BIT_GROUP0_IRQ_ENABLE   0
`define BIT_GROUP2_IRQ_ENABLE   3

`define MASK_GROUP0_EDGE 8'h0E
`define MASK_GROUP1_EDGE 8'h0F
`define MASK_GROUP2_EDGE 8'h3F
`define MASK_ENABLE_MAIN 8'hFF
`define MASK_ENABLE_SECOND 8'h1F

`define RESET_BYTE 8'h00

`endif

// ---- hdl/ext_int_pkg.sv ----
// Types shared by the external pin edge interrupt block.
// Assumes the params header sits beside it on the include path.
`include "ext_int_params.svh"

package ext_int_pkg;

  // Special function register access from the CPU core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_type;

  // Per-group CPU request levels and acknowledge strobes
  typedef struct packed {
    logic group2;
    logic group1;
    logic group0;
  } irq_group_type;

endpackage

// ---- hdl/pin_edge_detect.sv ----
// Pin synchroniser with rising and falling edge detection, one lane per pin.
// Assumes asynchronous pin inputs and a single system clock.
`timescale 1ns/1ps

module pin_edge_detect #(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk_i,  // System clock
  input  wire logic             rst_n_i,    // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] pin_i,      // Asynchronous pins
  output logic      [WIDTH-1:0] rise_o,     // One-cycle rising pulse
  output logic      [WIDTH-1:0] fall_o      // One-cycle falling pulse
);

  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, level_reg, rise_reg, fall_reg;
  logic [WIDTH-1:0] level_next, rise_next, fall_next;

  // ****************************************
  // Level accepted once two late stages agree
  // ****************************************
  always_comb begin
    level_next = level_reg;
    rise_next  = '0;
    fall_next  = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        level_next[i] = s3_reg[i];
        rise_next[i]  = s3_reg[i] & ~level_reg[i];
        fall_next[i]  = ~s3_reg[i] & level_reg[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
      rise_reg  <= '0;
      fall_reg  <= '0;
    end else begin
      s1_reg    <= pin_i;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
      rise_reg  <= rise_next;
      fall_reg  <= fall_next;
    end
  end

  assign rise_o = rise_reg;
  assign fall_o = fall_reg;

endmodule

// ---- verif/ext_int_props.sv ----
// Checker on the ports of the external pin edge interrupt block.
// Assumes pins change only between clock edges.
`timescale 1ns/1ps
module ext_int_props (
  input wire logic                       sys_clk_i,        // Clock
  input wire logic                       rst_n_i,          // Reset, active low
  input wire ext_int_pkg::sfr_req_type   sfr_req_i,        // SFR request
  input wire logic [7:0]                 sfr_rdata_o,      // Read data
  input wire logic                       sfr_hit_o,        // Read hit
  input wire logic [3:1]                 ext_pin_group0_i, // Group 0 pins
  input wire logic [3:0]                 ext_pin_group1_i, // Group 1 pins
  input wire logic [5:0]                 ext_pin_group2_i, // Group 2 pins
  input wire ext_int_pkg::irq_group_type irq_ack_i,        // Acknowledges
  input wire ext_int_pkg::irq_group_type irq_req_o         // Requests
);
  import ext_int_pkg::*;
  logic [12:0] pins_reg, pins_next;
  logic [2:0]  quiet_reg, quiet_next;
  logic        mapped;
  // ****
  // Cycles since any pin last moved
  // ****
  assign mapped = sfr_req_i.addr inside {8'h88, 8'hA8, 8'hA9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hC6, 8'hC7};
  always_comb begin
    pins_next  = {ext_pin_group2_i, ext_pin_group1_i, ext_pin_group0_i};
    quiet_next = (pins_next != pins_reg) ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h7};
    if (!rst_n_i) begin
      pins_next  = 13'h0;
      quiet_next = 3'h0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    pins_reg  <= pins_next;
    quiet_reg <= quiet_next;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_clears_g0: assert property (irq_ack_i.group0 && quiet_reg == 3'h7 && !sfr_req_i.wr |=> !irq_req_o.group0)
    else $error("group 0 request outlived its acknowledge");
  a_ack_clears_g1: assert property (irq_ack_i.group1 && quiet_reg == 3'h7 && !sfr_req_i.wr |=> !irq_req_o.group1)
    else $error("group 1 request outlived its acknowledge");
  a_ack_clears_g2: assert property (irq_ack_i.group2 && quiet_reg == 3'h7 && !sfr_req_i.wr |=> !irq_req_o.group2)
    else $error("group 2 request outlived its acknowledge");
  a_req_holds_level: assert property (!sfr_req_i.wr |=> (($past(irq_req_o) & ~$past(irq_ack_i) & ~irq_req_o) == 3'h0))
    else $error("request dropped without acknowledge or write");
  a_rise_has_cause: assert property ((irq_req_o & ~$past(irq_req_o)) != 3'h0 |-> $past(sfr_req_i.wr) || quiet_reg != 3'h7)
    else $error("request rose with quiet pins");
  a_read_hit_next: assert property (sfr_req_i.rd && mapped |=> sfr_hit_o)
    else $error("mapped read gave no hit");
  a_unmapped_zero: assert property (sfr_req_i.rd && !mapped |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
    else $error("unmapped read answered");
  a_hit_needs_read: assert property (sfr_hit_o |-> $past(sfr_req_i.rd))
    else $error("hit without read");
  cover property ($rose(irq_req_o.group0));
  cover property ($rose(irq_req_o.group2));
  cover property (irq_ack_i.group1 && irq_req_o.group1);
endmodule

bind ext_pin_edge_interrupts ext_int_props ext_int_props_inst (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
  .sfr_hit_o(sfr_hit_o), .ext_pin_group0_i(ext_pin_group0_i), .ext_pin_group1_i(ext_pin_group1_i),
  .ext_pin_group2_i(ext_pin_group2_i), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o));

// ---- verif/cpu_irq_responder.sv ----
// CPU response model: acknowledges pending requests after a chosen wait.
// Assumes the block holds each request level until acknowledged.
`timescale 1ns/1ps
module cpu_irq_responder (
  input  wire logic                       sys_clk_i, // Clock
  input  wire logic                       rst_n_i,   // Reset, active low
  input  wire logic                       resp_en_i, // CPU takes interrupts
  input  wire logic [1:0]                 delay_i,   // Wait before responding
  input  wire ext_int_pkg::irq_group_type irq_req_i, // Requests
  output ext_int_pkg::irq_group_type      irq_ack_o  // Response pulses
);
  import ext_int_pkg::*;
  logic [1:0] wait_reg;
  // ****
  // Response
  // ****
  always @(posedge sys_clk_i) begin
    if (!rst_n_i || !resp_en_i || irq_req_i == 3'h0 || irq_ack_o != 3'h0) begin
      wait_reg  <= 2'h0;
      irq_ack_o <= 3'h0;
    end else begin
      wait_reg  <= wait_reg + 2'h1;
      irq_ack_o <= (wait_reg == delay_i) ? irq_req_i : 3'h0;
    end
  end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the external pin edge interrupt block.
// Assumes the package, checker and CPU response model are compiled first.
`timescale 1ns/1ps
module tb;
  import ext_int_pkg::*;
  logic          sys_clk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  sfr_req_type   req = '0;
  logic [7:0]    rdata;
  logic          hit;
  logic [12:0]   pins = 13'h0;
  irq_group_type ack, irq;
  logic          resp_en = 1'b0;
  logic [1:0]    dly = 2'h0;
  logic [7:0]    lf = 8'h4E;
  int            err_total = 0;
  int            n_compared = 0;
  int            base[3] = '{0, 3, 7};
  int            cnt[3] = '{3, 4, 6};
  logic [7:0]    atab[9] = '{8'h88, 8'hA8, 8'hA9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hC6, 8'hC7};
  logic [7:0]    mtab[9] = '{8'h0A, 8'hFF, 8'h1F, 8'h0E, 8'h0E, 8'h0F, 8'h0F, 8'h3F, 8'h3F};
  always #4 sys_clk_i = ~sys_clk_i;
  ext_pin_edge_interrupts ext_pin_edge_interrupts_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_req_i(req), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .ext_pin_group0_i(pins[2:0]), .ext_pin_group1_i(pins[6:3]), .ext_pin_group2_i(pins[12:7]),
    .irq_ack_i(ack), .irq_req_o(irq));
  cpu_irq_responder cpu_irq_responder_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .resp_en_i(resp_en), .delay_i(dly), .irq_req_i(irq),
    .irq_ack_o(ack));
  // ****
  // Helpers
  // ****
  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_req(input logic [2:0] exp);
    chk_byte({5'h0, irq}, {5'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1 req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    tick(1);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    @(posedge sys_clk_i);
    #1 req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    tick(1);
    req.rd = 1'b0;
    chk_byte(rdata, exp);
    chk_byte({7'h0, hit}, {7'h0, exp_hit});
  endtask
  // One pin, random edge enables and gates, then the CPU responds
  task automatic pin_case(input int g, input int n);
    int         pos, flag;
    logic       fen, ren, up;
    logic [2:0] exp;
    pos = n + (g == 0);
    lf = step(lf);
    {fen, ren, up} = lf[2:0];
    pins[base[g] + n] = ~up;
    tick(8);
    wr(atab[3 + 2 * g], 8'(fen) << pos);
    wr(atab[4 + 2 * g], 8'(ren) << pos);
    lf = step(lf);
    wr(8'hA8, lf & 8'h85);
    wr(8'hA9, lf & 8'h08);
    pins[base[g] + n] = up;
    tick(10);
    flag = up ? ren : fen;
    exp = 3'(flag && lf[7] && (g == 0 ? lf[0] : g == 1 ? lf[2] : lf[3])) << g;
    chk_req(exp);
    if (g < 2) begin
      rd(8'h88, 8'(flag << (1 + 2 * g)), 1'b1);
    end
    wr(8'hA8, 8'h85);
    wr(8'hA9, 8'h08);
    chk_req(3'(flag) << g);
    dly = lf[5:4];
    resp_en = 1'b1;
    tick(12);
    chk_req(3'h0);
    resp_en = 1'b0;
    wr(atab[3 + 2 * g], 8'h00);
    wr(atab[4 + 2 * g], 8'h00);
  endtask
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    #80000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    tick(12);
    rst_n_i = 1'b1;
    tick(2);
    chk_req(3'h0);
    for (int i = 0; i < 9; i++) begin
      rd(atab[i], 8'h00, 1'b1);
      lf = step(lf);
      wr(atab[i], lf);
      rd(atab[i], lf & mtab[i], 1'b1);
    end
    wr(8'h90, 8'hFF);
    rd(8'h90, 8'h00, 1'b0);
    for (int i = 0; i < 9; i++) begin
      wr(atab[i], 8'h00);
    end
    chk_req(3'h0);
    for (int g = 0; g < 3; g++) begin
      for (int n = 0; n < cnt[g]; n++) begin
        pin_case(g, n);
      end
    end
    give_verdict();
  end
endmodule
